/* qsdf_top.sv */
// Transmit and receive queues, status registers and shift register of the
// quad serial interface data path.
// Assumes a 10 MHz CLOCK, a strobe register port and a free link clock pin.
//
// Design decisions made here: strobed register access and the register offsets.
`timescale 1ns/1ps
`default_nettype none
module qsdf_top
  import qsdf_pkg::*;
#(
  parameter int DEPTH = QSDF_DEPTH
) (
  input wire logic CLOCK,
  input wire logic RSTN,
  input wire logic [7:0] ADDR,
  input wire logic [31:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  output logic [31:0] RDATA,
  input wire logic LINK_CLK,
  input wire logic [3:0] DATA_IN,
  output logic [3:0] DATA_OUT,
  output logic DATA_OE,
  output logic BUSY
);
  localparam int CW = $clog2(DEPTH + 1);

  typedef enum logic [1:0] {QSDF_IDLE, QSDF_SHIFT, QSDF_DONE} qsdf_state_t;

  qsdf_state_t state_q;
  logic xfer_en_q;
  logic [QSDF_THR_W-1:0] rx_threshold_level_q;
  logic [7:0] flags_q;
  logic boot_hold_q;
  logic [31:0] tx_word_q;
  logic [31:0] serial_shift_reg_q;
  logic [2:0] nib_q;
  logic rx_underflow_q;
  logic tx_overflow_q;
  logic [31:0] rdata_q;
  logic [2:0] lclk_s;
  logic [3:0] din_s1;
  logic [3:0] din_s2;
  logic lclk_rise;

  logic tx_push, tx_pop, tx_full, tx_empty;
  logic rx_push, rx_pop, rx_full, rx_empty;
  logic [31:0] tx_head, rx_head;
  logic [CW-1:0] tx_cnt, rx_cnt;
  logic wr_tx, rd_rx, wr_int, wr_ctrl;
  logic rx_thr_hit, start_xfer;
  logic [7:0] flag_set;
  logic [7:0] flags_view;
  logic [9:0] rx_bytes;
  qsdf_stat1_t stat1;
  qsdf_stat2_t stat2;

  // Decoded register strobes
  assign wr_tx = WR && ADDR == QSDF_OFS_TX_WORD;
  assign wr_int = WR && ADDR == QSDF_OFS_INTSTAT;
  assign wr_ctrl = WR && ADDR == QSDF_OFS_CTRL;
  assign rd_rx = RD && ADDR == QSDF_OFS_RX_WORD;

  assign tx_push = wr_tx;
  assign rx_pop = rd_rx;

  // Transmit queue, up to eight command words
  qsdf_fifo #(.WIDTH(QSDF_WORD_W), .DEPTH(DEPTH)) u_txq (
    .clk(CLOCK),
    .rst_n(RSTN),
    .push(tx_push),
    .din(WDATA),
    .pop(tx_pop),
    .dout(tx_head),
    .full(tx_full),
    .empty(tx_empty),
    .count(tx_cnt)
  );

  // Receive queue, eight words deep
  qsdf_fifo #(.WIDTH(QSDF_WORD_W), .DEPTH(DEPTH)) u_rxq (
    .clk(CLOCK),
    .rst_n(RSTN),
    .push(rx_push),
    .din(serial_shift_reg_q),
    .pop(rx_pop),
    .dout(rx_head),
    .full(rx_full),
    .empty(rx_empty),
    .count(rx_cnt)
  );

  // Link clock crosses in through three flops, the data lines through two
  always_ff @(posedge CLOCK or negedge RSTN) begin
    if (!RSTN) begin
      lclk_s <= '0;
      din_s1 <= '0;
      din_s2 <= '0;
    end else begin
      lclk_s <= {lclk_s[1:0], LINK_CLK};
      din_s1 <= DATA_IN;
      din_s2 <= din_s1;
    end
  end
  // Edge found between the second and third stages, never the first
  assign lclk_rise = lclk_s[1] && !lclk_s[2];

  // Software control: transfer enable and self-clearing error clear
  always_ff @(posedge CLOCK or negedge RSTN) begin
    if (!RSTN) begin
      xfer_en_q <= 1'b0;
    end else if (wr_ctrl) begin
      xfer_en_q <= WDATA[QSDF_CTRL_XFER_EN];
    end
  end

  // Threshold resets to zero, as in boot operation
  always_ff @(posedge CLOCK or negedge RSTN) begin
    if (!RSTN) begin
      rx_threshold_level_q <= '0;
    end else if (WR && ADDR == QSDF_OFS_THR) begin
      rx_threshold_level_q <= WDATA[QSDF_THR_W-1:0];
    end
  end

  // Last word written to the transmit register, for read-back
  always_ff @(posedge CLOCK or negedge RSTN) begin
    if (!RSTN) begin
      tx_word_q <= QSDF_WORD_RESET;
    end else if (wr_tx) begin
      tx_word_q <= WDATA;
    end
  end

  // load oldest word when a transfer may begin
  assign start_xfer = (state_q == QSDF_IDLE) && xfer_en_q && !tx_empty;
  assign tx_pop = start_xfer;
  // completed word goes to the receive queue; dropped if it is full
  assign rx_push = (state_q == QSDF_DONE);

  // Transfer sequencer: one nibble per rising link clock edge
  always_ff @(posedge CLOCK or negedge RSTN) begin
    if (!RSTN) begin
      state_q <= QSDF_IDLE;
      nib_q <= '0;
    end else begin
      unique case (state_q)
        QSDF_IDLE: begin
          nib_q <= '0;
          if (start_xfer) begin
            state_q <= QSDF_SHIFT;
          end
        end
        QSDF_SHIFT: begin
          if (lclk_rise) begin
            nib_q <= nib_q + 1'b1;
            if (nib_q == 3'(QSDF_NIBBLES - 1)) begin
              state_q <= QSDF_DONE;
            end
          end
        end
        QSDF_DONE: begin
          state_q <= QSDF_IDLE;
        end
      endcase
    end
  end

  // Shift register: sample lines in, top nibble drives out
  always_ff @(posedge CLOCK or negedge RSTN) begin
    if (!RSTN) begin
      serial_shift_reg_q <= QSDF_WORD_RESET;
    end else if (start_xfer) begin
      serial_shift_reg_q <= tx_head;
    end else if (state_q == QSDF_SHIFT && lclk_rise) begin
      serial_shift_reg_q <= {serial_shift_reg_q[27:0], din_s2};
    end
  end

  // Output nibble comes straight from the shift register flops
  assign DATA_OUT = serial_shift_reg_q[31:28];
  assign DATA_OE = (state_q == QSDF_SHIFT);
  assign BUSY = (state_q != QSDF_IDLE);

  // sticky errors; a new event beats the clear
  always_ff @(posedge CLOCK or negedge RSTN) begin
    if (!RSTN) begin
      rx_underflow_q <= 1'b0;
      tx_overflow_q <= 1'b0;
    end else begin
      rx_underflow_q <= (rd_rx && rx_empty) ||
                        (rx_underflow_q && !(wr_ctrl && WDATA[QSDF_CTRL_ERR_CLR]));
      tx_overflow_q <= (wr_tx && tx_full) ||
                       (tx_overflow_q && !(wr_ctrl && WDATA[QSDF_CTRL_ERR_CLR]));
    end
  end

  // threshold counts bytes; 10 bits hold eight words of four bytes
  assign rx_bytes = 10'(rx_cnt) * 10'(QSDF_BYTES_PER_WORD);
  assign rx_thr_hit = rx_bytes >= 10'(rx_threshold_level_q);

  // Hardware conditions that set the interrupt status flags
  always_comb begin
    flag_set = '0;
    flag_set[QSDF_IF_TX_EMPTY] = tx_empty;
    flag_set[QSDF_IF_TX_FULL] = tx_full;
    flag_set[QSDF_IF_RX_EMPTY] = rx_empty;
    flag_set[QSDF_IF_RX_FULL] = rx_full;
    flag_set[QSDF_IF_RX_THR] = rx_thr_hit;
  end

  // write-one-to-clear with set winning over the clear
  always_ff @(posedge CLOCK or negedge RSTN) begin
    if (!RSTN) begin
      flags_q <= QSDF_IF_RESET;
    end else begin
      flags_q <= (flag_set | (flags_q & ~(wr_int ? WDATA[7:0] : 8'h00))) & QSDF_IF_MASK;
    end
  end

  // threshold flag held high until the first bus read
  always_ff @(posedge CLOCK or negedge RSTN) begin
    if (!RSTN) begin
      boot_hold_q <= 1'b1;
    end else if (RD) begin
      boot_hold_q <= 1'b0;
    end
  end

  // transmit flags show the live queue state; the stored bits lag a cycle
  always_comb begin
    flags_view = flags_q;
    flags_view[QSDF_IF_TX_EMPTY] = tx_empty;
    flags_view[QSDF_IF_TX_FULL] = tx_full;
    flags_view[QSDF_IF_RX_THR] = flags_q[QSDF_IF_RX_THR] | boot_hold_q;
  end

  assign stat1 = '{pad_hi: 8'h00, tx_free_slots: 8'(DEPTH) - 8'(tx_cnt),
                   pad_mid: 8'h00, rx_word_count: 8'(rx_cnt)};

  // line presence and errors, other bits zero
  assign stat2 = '{pad_hi: 25'h0000000, data_lines: din_s2, pad_lo: 1'b0,
                   rx_underflow: rx_underflow_q, tx_overflow: tx_overflow_q};

  // Read data stands one cycle after the strobe and is zero otherwise
  always_ff @(posedge CLOCK or negedge RSTN) begin
    if (!RSTN) begin
      rdata_q <= '0;
    end else if (!RD) begin
      rdata_q <= '0;
    end else begin
      unique case (ADDR)
        QSDF_OFS_CTRL: rdata_q <= {31'h00000000, xfer_en_q};
        QSDF_OFS_THR: rdata_q <= {27'h0000000, rx_threshold_level_q};
        QSDF_OFS_INTSTAT: rdata_q <= {24'h000000, flags_view};
        QSDF_OFS_TX_WORD: rdata_q <= tx_word_q;
        QSDF_OFS_RX_WORD: rdata_q <= rx_empty ? QSDF_WORD_RESET : rx_head;
        QSDF_OFS_STAT1: rdata_q <= stat1;
        QSDF_OFS_STAT2: rdata_q <= stat2;
        default: rdata_q <= '0;
      endcase
    end
  end
  assign RDATA = rdata_q;

  // Checks, all in the system clock domain
  default clocking cb @(posedge CLOCK);
  endclocking
  default disable iff (!RSTN);

  w1c_clear_a: assert property (
    wr_int && WDATA[QSDF_IF_RX_FULL] && !rx_full |=> !flags_q[QSDF_IF_RX_FULL])
    else $error("status flag not cleared by write of one");

  w1c_keep_a: assert property (
    wr_int && !WDATA[QSDF_IF_RX_FULL] && flags_q[QSDF_IF_RX_FULL]
      |=> flags_q[QSDF_IF_RX_FULL])
    else $error("status flag lost on write of zero");

  boot_hold_a: assert property (
    RD && ADDR == QSDF_OFS_INTSTAT && boot_hold_q |=> RDATA[QSDF_IF_RX_THR])
    else $error("threshold flag low before first read");

  tx_full_flag_a: assert property (
    flags_view[QSDF_IF_TX_FULL] == (u_txq.count == CW'(DEPTH)))
    else $error("transmit full flag wrong");

  tx_empty_flag_a: assert property (
    ##1 flags_view[QSDF_IF_TX_EMPTY] == (tx_cnt == '0))
    else $error("transmit empty flag wrong");

  load_oldest_a: assert property (
    start_xfer |=> serial_shift_reg_q == $past(tx_head) && state_q == QSDF_SHIFT)
    else $error("shift register not loaded with oldest word");

  tx_accept_a: assert property (
    wr_tx && !tx_full && BUSY && !tx_pop |=> tx_cnt == $past(tx_cnt) + 1'b1)
    else $error("transmit write lost during transfer");

  tx_bound_a: assert property (
    tx_cnt <= CW'(DEPTH))
    else $error("transmit queue above depth");

  rx_capture_a: assert property (
    state_q == QSDF_DONE && !rx_full && !rx_pop |=> rx_cnt == $past(rx_cnt) + 1'b1)
    else $error("finished word not queued");

  rx_read_a: assert property (
    rd_rx && !rx_empty |=> RDATA == $past(rx_head))
    else $error("receive read did not return oldest word");

  stat1_a: assert property (
    RD && ADDR == QSDF_OFS_STAT1
      |=> RDATA[23:16] == 8'(DEPTH) - 8'($past(tx_cnt)) && RDATA[7:0] == 8'($past(rx_cnt)))
    else $error("queue level status wrong");

  stat2_zero_a: assert property (
    RD && ADDR == QSDF_OFS_STAT2 |=> RDATA[31:7] == '0 && !RDATA[2])
    else $error("line status reserved bits set");

  underflow_a: assert property (
    rd_rx && rx_empty |=> rx_underflow_q && RDATA == '0)
    else $error("underflow not flagged");

  overflow_a: assert property (
    wr_tx && tx_full |=> tx_overflow_q && tx_cnt == $past(tx_cnt))
    else $error("overflow not flagged or write not dropped");

  threshold_a: assert property (
    rx_thr_hit |=> flags_q[QSDF_IF_RX_THR])
    else $error("threshold flag not set");

  frame_len_a: assert property (
    $fell(DATA_OE) |-> state_q == QSDF_DONE && $past(lclk_rise) && $past(nib_q) == 3'(QSDF_NIBBLES - 1))
    else $error("transfer length wrong");

  full_cov: cover property (tx_full && wr_tx);
  xfer_cov: cover property (state_q == QSDF_DONE);
  read_cov: cover property (rd_rx && !rx_empty);
  clear_cov: cover property (wr_int && WDATA[QSDF_IF_RX_FULL] && flags_q[QSDF_IF_RX_FULL]);

endmodule
`default_nettype wire

/* qsdf_pkg.sv */
// Constants, register map and field layouts for the quad serial data queues.
// Assumes a single 10 MHz system clock and a plain strobe register port.
package qsdf_pkg;

  // Register byte offsets
  localparam logic [7:0] QSDF_OFS_CTRL = 8'h00;
  localparam logic [7:0] QSDF_OFS_THR = 8'h04;
  localparam logic [7:0] QSDF_OFS_INTSTAT = 8'h08;
  localparam logic [7:0] QSDF_OFS_TX_WORD = 8'h0c;
  localparam logic [7:0] QSDF_OFS_RX_WORD = 8'h10;
  localparam logic [7:0] QSDF_OFS_STAT1 = 8'h14;
  localparam logic [7:0] QSDF_OFS_STAT2 = 8'h18;

  // Control register fields
  localparam int QSDF_CTRL_XFER_EN = 0;
  localparam int QSDF_CTRL_ERR_CLR = 1;
  localparam int QSDF_THR_W = 5;

  // Interrupt status bit positions
  localparam int QSDF_IF_TX_EMPTY = 0;
  localparam int QSDF_IF_TX_FULL = 1;
  localparam int QSDF_IF_RX_EMPTY = 3;
  localparam int QSDF_IF_RX_FULL = 4;
  localparam int QSDF_IF_RX_THR = 5;
  localparam logic [7:0] QSDF_IF_RESET = 8'h29;
  localparam logic [7:0] QSDF_IF_MASK = 8'h3b;

  // Queue geometry and serial framing
  localparam int QSDF_DEPTH = 8;
  localparam int QSDF_WORD_W = 32;
  localparam int QSDF_LINES = 4;
  localparam int QSDF_NIBBLES = QSDF_WORD_W / QSDF_LINES;
  localparam int QSDF_BYTES_PER_WORD = 4;

  localparam logic [31:0] QSDF_WORD_RESET = 32'h00000000;

  // Queue level status layout
  typedef struct packed {
    logic [7:0] pad_hi;
    logic [7:0] tx_free_slots;
    logic [7:0] pad_mid;
    logic [7:0] rx_word_count;
  } qsdf_stat1_t;

  // Line and error status layout
  typedef struct packed {
    logic [24:0] pad_hi;
    logic [3:0] data_lines;
    logic pad_lo;
    logic rx_underflow;
    logic tx_overflow;
  } qsdf_stat2_t;

endpackage

/* qsdf_fifo.sv */
// Word queue built from flip-flops, indexed by read and write pointers.
// Assumes the owner never relies on a push or pop that the flags refuse.
`timescale 1ns/1ps
`default_nettype none
module qsdf_fifo #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 8,
  parameter int CW = $clog2(DEPTH + 1)
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic push,
  input wire logic [WIDTH-1:0] din,
  input wire logic pop,
  output logic [WIDTH-1:0] dout,
  output logic full,
  output logic empty,
  output logic [CW-1:0] count
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam logic [CW-1:0] DEPTH_C = CW'(DEPTH);
  localparam logic [AW-1:0] LAST_C = AW'(DEPTH - 1);

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0] wr_q;
  logic [AW-1:0] rd_q;
  logic [CW-1:0] count_q;
  logic do_push;
  logic do_pop;

  // Refused pushes and pops leave the pointers alone
  assign do_push = push && (count_q != DEPTH_C);
  assign do_pop = pop && (count_q != '0);
  assign full = (count_q == DEPTH_C);
  assign empty = (count_q == '0);
  assign count = count_q;
  assign dout = mem_q[rd_q];

  // One storage word per entry
  for (genvar i = 0; i < DEPTH; i++) begin : g_entry
    always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
        mem_q[i] <= '0;
      end else if (do_push && wr_q == AW'(i)) begin
        mem_q[i] <= din;
      end
    end
  end

  // Pointers wrap at the configured depth, which need not be a power of two
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_q <= '0;
      rd_q <= '0;
    end else begin
      if (do_push) begin
        wr_q <= (wr_q == LAST_C) ? '0 : wr_q + 1'b1;
      end
      if (do_pop) begin
        rd_q <= (rd_q == LAST_C) ? '0 : rd_q + 1'b1;
      end
    end
  end

  // Fill level
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      count_q <= '0;
    end else if (do_push && !do_pop) begin
      count_q <= count_q + 1'b1;
    end else if (do_pop && !do_push) begin
      count_q <= count_q - 1'b1;
    end
  end
endmodule
`default_nettype wire

/* qsdf_mem_model.sv */
// Behavioural serial quad memory on the far side of the four data lines.
// Assumes the block drives data_oe for one word frame of eight link edges.
`timescale 1ns/1ps
`default_nettype none
module qsdf_mem_model (
  output logic link_clk,
  output logic [3:0] data_in,
  input wire logic [3:0] data_out,
  input wire logic data_oe,
  output int frames,
  output logic [31:0] got_words [16]
);
  logic [31:0] resp;
  logic [31:0] cap;

  // One frame per rise of the enable; the link clock stands still between frames
  initial begin
    link_clk = 1'b0;
    data_in = 4'ha;
    frames = 0;
    cap = 32'h00000000;
    forever begin
      @(posedge data_oe);
      resp = 32'h5a3c9600 + 32'(frames);
      #130;
      for (int i = 0; i < 8; i++) begin
        data_in = resp[31 - 4 * i -: 4];
        #400;
        cap = {cap[27:0], data_out};
        link_clk = 1'b1;
        #400;
        link_clk = 1'b0;
      end
      got_words[frames] = cap;
      frames++;
      // Released lines show the inverse so a stale value is never mistaken
      data_in = ~data_in;
    end
  end
endmodule
`default_nettype wire

/* test_qsdf_top.sv */
// Self-checking bench for the quad serial data queues and status registers.
// Assumes qsdf_top with the memory model serving link clock and data lines.
`timescale 1ns/1ps
`default_nettype none
module test_qsdf_top
  import qsdf_pkg::*;
;
  logic clock = 1'b0;
  logic rstn;
  logic [7:0] addr;
  logic [31:0] wdata;
  logic wr;
  logic rd;
  logic [31:0] rdata;
  logic link_clk;
  logic [3:0] data_in;
  logic [3:0] data_out;
  logic data_oe;
  logic busy;
  int frames;
  logic [31:0] got_words [16];
  int failures = 0;
  int checks_done = 0;
  logic [31:0] rv;

  // 10 MHz system clock
  always #50 clock = ~clock;

  qsdf_top uut (
    .CLOCK(clock),
    .RSTN(rstn),
    .ADDR(addr),
    .WDATA(wdata),
    .WR(wr),
    .RD(rd),
    .RDATA(rdata),
    .LINK_CLK(link_clk),
    .DATA_IN(data_in),
    .DATA_OUT(data_out),
    .DATA_OE(data_oe),
    .BUSY(busy)
  );

  qsdf_mem_model mem (
    .link_clk(link_clk),
    .data_in(data_in),
    .data_out(data_out),
    .data_oe(data_oe),
    .frames(frames),
    .got_words(got_words)
  );

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      failures++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  // Strobes are one cycle; the trailing low keeps two writes a cycle apart
  task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clock);
    wr <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe edge
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    @(posedge clock);
    addr <= a;
    rd <= 1'b1;
    @(posedge clock);
    rd <= 1'b0;
    #1;
    chk(rdata, exp);
  endtask

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  task automatic t_reset_values();
    rd_chk(QSDF_OFS_INTSTAT, 32'h00000029);
    rd_chk(QSDF_OFS_STAT1, 32'h00080000);
    rd_chk(QSDF_OFS_STAT2, 32'h00000050);
    rd_chk(8'hfc, 32'h00000000);
  endtask

  // Raise the threshold so its flag can stay cleared, then clear it
  task automatic t_w1c();
    reg_wr(QSDF_OFS_THR, 32'h0000001f);
    reg_wr(QSDF_OFS_INTSTAT, 32'h00000000);
    rd_chk(QSDF_OFS_INTSTAT, 32'h00000029);
    reg_wr(QSDF_OFS_INTSTAT, 32'h00000020);
    rd_chk(QSDF_OFS_INTSTAT, 32'h00000009);
  endtask

  task automatic t_tx_fill();
    for (int i = 0; i < QSDF_DEPTH; i++) begin
      reg_wr(QSDF_OFS_TX_WORD, 32'h81000000 + 32'(i));
      rd_chk(QSDF_OFS_STAT1, 32'(QSDF_DEPTH - 1 - i) << 16);
    end
    rd_chk(QSDF_OFS_INTSTAT, 32'h0000000a);
    reg_wr(QSDF_OFS_TX_WORD, 32'hffffffff);
    rd_chk(QSDF_OFS_STAT2, 32'h00000051);
    rd_chk(QSDF_OFS_STAT1, 32'h00000000);
  endtask

  // Nine words cross; the ninth reply is lost because the receive queue is full
  task automatic t_transfer();
    reg_wr(QSDF_OFS_CTRL, 32'h00000001);
    for (int n = 0; n < 60 && busy !== 1'b1; n++) @(posedge clock);
    chk({31'h0, busy}, 32'h00000001);
    rd_chk(QSDF_OFS_STAT1, 32'h00010000);
    reg_wr(QSDF_OFS_TX_WORD, 32'h81000008);
    rd_chk(QSDF_OFS_STAT1, 32'h00000000);
    for (int n = 0; n < 2000 && !(frames == 9 && busy === 1'b0); n++) @(posedge clock);
    repeat (4) @(posedge clock);
    chk(32'(frames), 32'h00000009);
    for (int i = 0; i < 9; i++) begin
      chk(got_words[i], 32'h81000000 + 32'(i));
    end
    rd_chk(QSDF_OFS_STAT1, 32'h00080008);
    rd_chk(QSDF_OFS_INTSTAT, 32'h00000039);
    reg_wr(QSDF_OFS_INTSTAT, 32'h00000008);
    rd_chk(QSDF_OFS_INTSTAT, 32'h00000031);
  endtask

  task automatic t_drain();
    for (int i = 0; i < QSDF_DEPTH; i++) begin
      rd_chk(QSDF_OFS_RX_WORD, 32'h5a3c9600 + 32'(i));
      rd_chk(QSDF_OFS_STAT1, 32'h00080000 | 32'(QSDF_DEPTH - 1 - i));
    end
    rd_chk(QSDF_OFS_RX_WORD, 32'h00000000);
    rd_chk(QSDF_OFS_STAT2, 32'h0000003b);
    reg_wr(QSDF_OFS_CTRL, 32'h00000002);
    rd_chk(QSDF_OFS_STAT2, 32'h00000038);
    rd_chk(QSDF_OFS_INTSTAT, 32'h00000039);
    reg_wr(QSDF_OFS_INTSTAT, 32'h00000010);
    rd_chk(QSDF_OFS_INTSTAT, 32'h00000029);
  endtask

  // A second reset in mid-run brings the threshold back to zero
  task automatic t_rereset();
    @(posedge clock);
    rstn <= 1'b0;
    repeat (2) @(posedge clock);
    rstn <= 1'b1;
    rd_chk(QSDF_OFS_INTSTAT, 32'h00000029);
    rd_chk(QSDF_OFS_STAT1, 32'h00080000);
    rd_chk(QSDF_OFS_THR, 32'h00000000);
  endtask

  // Watchdog sized well beyond the several hundred cycles the run needs
  initial begin
    #1000000;
    failures++;
    print_verdict();
  end

  initial begin
    rstn = 1'b0;
    addr = 8'h00;
    wdata = 32'h00000000;
    wr = 1'b0;
    rd = 1'b0;
    repeat (2) @(posedge clock);
    rstn <= 1'b1;
    t_reset_values();
    t_w1c();
    t_tx_fill();
    t_transfer();
    t_drain();
    t_rereset();
    print_verdict();
  end
endmodule
`default_nettype wire
